// ### core/ptis_pkg.sv
package ptis_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PORT_COUNT = 16;
    localparam int PORT_AW    = 4;
    localparam int LINE_COUNT = 7;
    localparam int SETUP_W    = 6;
    localparam int APB_AW     = 12;
    localparam int CMP_CNT_W  = 16;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] ADDR_IRQ_STATUS   = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_IRQ_MASK     = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_PORT_INDEX   = 12'h008;
    localparam logic [APB_AW-1:0] ADDR_PORT_SETUP   = 12'h00C;
    localparam logic [APB_AW-1:0] ADDR_COMPARE_CNT  = 12'h010;

    // ------------------------------------------------------------
    // Port control setup fields
    // ------------------------------------------------------------
    localparam int SETUP_SEL_LSB  = 0;
    localparam int SETUP_SINK_BIT = 3;
    localparam int SETUP_SRC_BIT  = 4;
    localparam int SETUP_KEEP_BIT = 5;

    // ------------------------------------------------------------
    // Reset values and select codes
    // ------------------------------------------------------------
    localparam logic [SETUP_W-1:0]    SETUP_RESET      = 6'h00;
    localparam logic [LINE_COUNT-1:0] IRQ_MASK_RESET   = 7'h00;
    localparam logic [LINE_COUNT-1:0] IRQ_STATUS_RESET = 7'h00;
    localparam logic [PORT_AW-1:0]    PORT_INDEX_RESET = 4'h0;
    localparam logic [2:0]            SEL_NONE         = 3'h0;
    localparam logic [2:0]            SEL_SEVEN        = 3'h7;

    typedef struct packed {
        logic       keep_errored_frames;
        logic       source_role;
        logic       sink_role;
        logic [2:0] port_interrupt_select;
    } ptis_setup_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LOOKUP = 2'b01,
        ST_COMMIT = 2'b10,
        ST_SIGNAL = 2'b11
    } ptis_state_t;

    // Select code to one-hot line vector, line one in bit 0, code zero to no line
    function automatic logic [LINE_COUNT-1:0] ptis_line_decode(input logic [2:0] sel);
        logic [LINE_COUNT-1:0] v;
        v = 7'h00;
        if (sel != SEL_NONE) begin
            v[sel - 3'h1] = 1'b1;
        end
        return v;
    endfunction

endpackage

// ### core/ptis_setup_if.sv
`timescale 1ns/1ps
interface ptis_setup_if;
    import ptis_pkg::*;
    logic                       wr_en;
    logic [PORT_AW-1:0]         wr_addr;
    logic [SETUP_W-1:0]         wr_data;
    logic [PORT_AW-1:0]         a_addr;
    logic [SETUP_W-1:0]         a_data;
    logic [PORT_AW-1:0]         b_addr;
    logic [SETUP_W-1:0]         b_data;

    modport mem (input wr_en, input wr_addr, input wr_data, input a_addr, input b_addr,
                 output a_data, output b_data);
    modport ctl (output wr_en, output wr_addr, output wr_data, output a_addr, output b_addr,
                 input a_data, input b_data);
endinterface

// ### core/ptis_setup_mem.sv
`timescale 1ns/1ps
module ptis_setup_mem
    import ptis_pkg::*;
(
    input  wire logic   CLK,
    input  wire logic   RESETN,
    ptis_setup_if.mem   mp
);

    logic [SETUP_W-1:0] mem_reg [PORT_COUNT];

    // ------------------------------------------------------------
    // Storage, one write port
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                mem_reg[i] <= SETUP_RESET;
            end
        end else if (mp.wr_en) begin
            mem_reg[mp.wr_addr] <= mp.wr_data;
        end
    end

    // ------------------------------------------------------------
    // Two registered read ports
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mp.a_data <= SETUP_RESET;
            mp.b_data <= SETUP_RESET;
        end else begin
            mp.a_data <= mem_reg[mp.a_addr];
            mp.b_data <= mem_reg[mp.b_addr];
        end
    end

endmodule // ptis_setup_mem

// ### core/ptis_top.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ptis_top
    import ptis_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RESETN,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [APB_AW-1:0]      PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic [31:0]                 PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic                   XFER_VALID,
    output logic                        XFER_READY,
    input  wire logic [PORT_AW-1:0]     XFER_PORT,
    input  wire logic                   XFER_ERROR,
    input  wire logic                   XFER_SIZE_MISMATCH,
    output logic                        XFER_COMMIT,
    output logic [PORT_AW-1:0]          COMMIT_PORT,
    output logic [LINE_COUNT-1:0]       DATA_TRANSFER_INTERRUPT_LINE,
    output logic                        COMPARE_START,
    output logic [PORT_AW-1:0]          COMPARE_PORT,
    output logic                        IRQ
);

    ptis_setup_if                       setup_bus ();

    ptis_state_t                        state_reg;
    ptis_state_t                        state_next;
    logic [PORT_AW-1:0]                 port_reg;
    logic                               err_reg;
    logic                               mismatch_reg;
    logic                               commit_reg;
    logic                               cmp_pend_reg;
    logic [LINE_COUNT-1:0]              line_pend_reg;
    logic [LINE_COUNT-1:0]              line_reg;
    logic                               cmp_reg;
    logic [PORT_AW-1:0]                 cmp_port_reg;
    logic [LINE_COUNT-1:0]              status_reg;
    logic [LINE_COUNT-1:0]              mask_reg;
    logic [PORT_AW-1:0]                 index_reg;
    logic [CMP_CNT_W-1:0]               cmp_cnt_reg;
    logic [31:0]                        prdata_reg;
    logic                               pslverr_reg;

    ptis_setup_t                        cfg;
    logic                               is_receiver;
    logic                               is_active;
    logic                               store_ok;
    logic                               sel_seven;
    logic                               cmp_ok;
    logic [LINE_COUNT-1:0]              line_ok;
    logic                               apb_acc;
    logic                               apb_wr;
    logic                               apb_rd;
    logic                               addr_hit;

    // ------------------------------------------------------------
    // Setup table
    // ------------------------------------------------------------
    ptis_setup_mem u_setup_mem (
        .CLK    (CLK),
        .RESETN (RESETN),
        .mp     (setup_bus.mem)
    );

    assign setup_bus.wr_en   = apb_wr && (PADDR == ADDR_PORT_SETUP);
    assign setup_bus.wr_addr = index_reg;
    assign setup_bus.wr_data = PWDATA[SETUP_W-1:0];
    assign setup_bus.a_addr  = index_reg;
    assign setup_bus.b_addr  = port_reg;

    // ------------------------------------------------------------
    // Transfer decision
    // ------------------------------------------------------------
    assign cfg         = ptis_setup_t'(setup_bus.b_data);
    assign is_receiver = cfg.sink_role && !cfg.source_role;
    assign is_active   = cfg.sink_role || cfg.source_role;
    assign sel_seven   = (cfg.port_interrupt_select == SEL_SEVEN);

    // Errored frames count only when kept and size is intact
    assign store_ok = is_active &&
                      (!err_reg ||
                       (is_receiver && cfg.keep_errored_frames && !mismatch_reg));

    // Seven never drives a plain line
    assign line_ok = (store_ok && !sel_seven) ?
                     ptis_line_decode(cfg.port_interrupt_select) : 7'h00;
    assign cmp_ok  = store_ok && is_receiver && sel_seven;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (XFER_VALID) begin
                    state_next = ST_LOOKUP;
                end
            end
            ST_LOOKUP: state_next = ST_COMMIT;
            ST_COMMIT: state_next = ST_SIGNAL;
            ST_SIGNAL: state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    assign XFER_READY = (state_reg == ST_IDLE);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            port_reg     <= PORT_INDEX_RESET;
            err_reg      <= 1'b0;
            mismatch_reg <= 1'b0;
        end else if (XFER_VALID && XFER_READY) begin
            port_reg     <= XFER_PORT;
            err_reg      <= XFER_ERROR;
            mismatch_reg <= XFER_SIZE_MISMATCH;
        end
    end

    // Commit first, line pulse one cycle later
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            commit_reg    <= 1'b0;
            line_pend_reg <= 7'h00;
            cmp_pend_reg  <= 1'b0;
        end else if (state_reg == ST_COMMIT) begin
            commit_reg    <= store_ok;
            line_pend_reg <= line_ok;
            cmp_pend_reg  <= cmp_ok;
        end else begin
            commit_reg    <= 1'b0;
            line_pend_reg <= 7'h00;
            cmp_pend_reg  <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            line_reg     <= 7'h00;
            cmp_reg      <= 1'b0;
            cmp_port_reg <= PORT_INDEX_RESET;
        end else begin
            line_reg     <= line_pend_reg;
            cmp_reg      <= cmp_pend_reg;
            cmp_port_reg <= port_reg;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cmp_cnt_reg <= '0;
        end else if (cmp_reg) begin
            cmp_cnt_reg <= cmp_cnt_reg + 16'h0001;
        end
    end

    assign XFER_COMMIT                  = commit_reg;
    assign COMMIT_PORT                  = port_reg;
    assign DATA_TRANSFER_INTERRUPT_LINE = line_reg;
    assign COMPARE_START                = cmp_reg;
    assign COMPARE_PORT                 = cmp_port_reg;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign apb_acc  = PSEL && PENABLE;
    assign apb_wr   = apb_acc && PWRITE;
    assign apb_rd   = apb_acc && !PWRITE;
    assign addr_hit = (PADDR == ADDR_IRQ_STATUS) || (PADDR == ADDR_IRQ_MASK) ||
                      (PADDR == ADDR_PORT_INDEX) || (PADDR == ADDR_PORT_SETUP) ||
                      (PADDR == ADDR_COMPARE_CNT);
    assign PREADY   = 1'b1;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_reg  <= IRQ_MASK_RESET;
            index_reg <= PORT_INDEX_RESET;
        end else if (apb_wr) begin
            if (PADDR == ADDR_IRQ_MASK) begin
                mask_reg <= PWDATA[LINE_COUNT-1:0];
            end
            if (PADDR == ADDR_PORT_INDEX) begin
                index_reg <= PWDATA[PORT_AW-1:0];
            end
        end
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            status_reg <= IRQ_STATUS_RESET;
        end else if (apb_wr && (PADDR == ADDR_IRQ_STATUS)) begin
            status_reg <= (status_reg & ~PWDATA[LINE_COUNT-1:0]) | line_pend_reg;
        end else begin
            status_reg <= status_reg | line_pend_reg;
        end
    end

    assign IRQ = |(status_reg & mask_reg);

    // Read data sampled in setup cycle, valid in access cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            pslverr_reg <= !addr_hit;
            case (PADDR)
                ADDR_IRQ_STATUS:  prdata_reg <= {25'h0000000, status_reg | line_pend_reg};
                ADDR_IRQ_MASK:    prdata_reg <= {25'h0000000, mask_reg};
                ADDR_PORT_INDEX:  prdata_reg <= {28'h0000000, index_reg};
                ADDR_PORT_SETUP:  prdata_reg <= {26'h0000000, setup_bus.a_data};
                ADDR_COMPARE_CNT: prdata_reg <= {16'h0000, cmp_cnt_reg};
                default:          prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign PRDATA  = apb_rd ? prdata_reg : 32'h0000_0000;
    assign PSLVERR = apb_acc && pslverr_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    logic in_commit;
    assign in_commit = (state_reg == ST_COMMIT);

    clean_line_a: assert property (
        in_commit && is_active && !err_reg &&
        (cfg.port_interrupt_select != SEL_NONE) && !sel_seven
        |-> ##2 (DATA_TRANSFER_INTERRUPT_LINE ==
                 ptis_line_decode($past(cfg.port_interrupt_select, 2))))
        else $error("clean transfer did not raise its line");

    recover_line_a: assert property (
        in_commit && is_receiver && err_reg && cfg.keep_errored_frames &&
        !mismatch_reg && (cfg.port_interrupt_select != SEL_NONE) && !sel_seven
        |-> ##1 XFER_COMMIT ##1 (DATA_TRANSFER_INTERRUPT_LINE != 7'h00))
        else $error("recoverable frame did not raise its line");

    error_quiet_a: assert property (
        in_commit && err_reg && !(is_receiver && cfg.keep_errored_frames && !mismatch_reg)
        |-> ##1 !XFER_COMMIT ##1 (DATA_TRANSFER_INTERRUPT_LINE == 7'h00) && !COMPARE_START)
        else $error("errored transfer raised an interrupt");

    select_zero_a: assert property (
        in_commit && (cfg.port_interrupt_select == SEL_NONE)
        |-> ##2 (DATA_TRANSFER_INTERRUPT_LINE == 7'h00) && !COMPARE_START)
        else $error("select zero raised an interrupt");

    line_map_a: assert property (
        (DATA_TRANSFER_INTERRUPT_LINE != 7'h00)
        |-> $onehot(DATA_TRANSFER_INTERRUPT_LINE) &&
            (DATA_TRANSFER_INTERRUPT_LINE ==
             ptis_line_decode($past(cfg.port_interrupt_select, 2))))
        else $error("line does not match select code");

    compare_sink_a: assert property (
        in_commit && store_ok && is_receiver && sel_seven
        |-> ##2 COMPARE_START && (COMPARE_PORT == $past(port_reg, 2)) &&
            (DATA_TRANSFER_INTERRUPT_LINE == 7'h00))
        else $error("comparison not started on receiving port");

    source_seven_a: assert property (
        in_commit && cfg.source_role && sel_seven
        |-> ##2 (DATA_TRANSFER_INTERRUPT_LINE == 7'h00) && !COMPARE_START)
        else $error("transmitting port with seven raised something");

    mismatch_drop_a: assert property (
        in_commit && err_reg && mismatch_reg |=> !XFER_COMMIT)
        else $error("size mismatch frame was stored");

    role_both_a: assert property (
        in_commit && cfg.sink_role && cfg.source_role && sel_seven |-> ##2 !COMPARE_START)
        else $error("source role did not override sink role");

    after_commit_a: assert property (
        (DATA_TRANSFER_INTERRUPT_LINE != 7'h00)
        |-> $past(XFER_COMMIT) ##1 (DATA_TRANSFER_INTERRUPT_LINE == 7'h00))
        else $error("line pulse not single or not after commit");

    status_set_a: assert property (
        (DATA_TRANSFER_INTERRUPT_LINE != 7'h00)
        |-> ((status_reg & DATA_TRANSFER_INTERRUPT_LINE) == DATA_TRANSFER_INTERRUPT_LINE))
        else $error("line pulse did not set its status bit");

    busy_window_a: assert property (
        XFER_VALID && XFER_READY
        |=> !XFER_READY [*3] ##1 XFER_READY)
        else $error("transfer port not busy for three cycles");

    seven_dark_a: assert property (
        !DATA_TRANSFER_INTERRUPT_LINE[LINE_COUNT-1])
        else $error("line seven driven as a plain line");

    mismatch_quiet_a: assert property (
        in_commit && err_reg && mismatch_reg
        |-> ##2 (DATA_TRANSFER_INTERRUPT_LINE == 7'h00) && !COMPARE_START)
        else $error("size mismatch frame raised an interrupt");

    compare_count_a: assert property (
        COMPARE_START
        |=> (cmp_cnt_reg == $past(cmp_cnt_reg) + 16'h0001))
        else $error("comparison start not counted");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    clean_xfer_c:   cover property (in_commit && !err_reg && (line_ok != 7'h00));
    mismatch_c:     cover property (in_commit && err_reg && mismatch_reg);
    recover_xfer_c: cover property (in_commit && err_reg && (line_ok != 7'h00));
    compare_c:      cover property (COMPARE_START);
    irq_clear_c:    cover property (IRQ ##[1:20] !IRQ);

endmodule // ptis_top

// ### sim/ptis_top_test.sv
`timescale 1ns/1ps
module ptis_top_test
    import ptis_pkg::*;
;
    logic                  CLK = 1'b0;
    logic                  RESETN = 1'b0;
    logic                  PSEL = 1'b0;
    logic                  PENABLE = 1'b0;
    logic                  PWRITE = 1'b0;
    logic [APB_AW-1:0]     PADDR = 12'h000;
    logic [31:0]           PWDATA = 32'h0;
    logic [31:0]           PRDATA;
    logic                  PREADY;
    logic                  PSLVERR;
    logic                  XFER_VALID = 1'b0;
    logic                  XFER_READY;
    logic [PORT_AW-1:0]    XFER_PORT = 4'h0;
    logic                  XFER_ERROR = 1'b0;
    logic                  XFER_SIZE_MISMATCH = 1'b0;
    logic                  XFER_COMMIT;
    logic [PORT_AW-1:0]    COMMIT_PORT;
    logic [LINE_COUNT-1:0] DATA_TRANSFER_INTERRUPT_LINE;
    logic                  COMPARE_START;
    logic [PORT_AW-1:0]    COMPARE_PORT;
    logic                  IRQ;
    int                    bad_count = 0;
    int                    checks_done = 0;
    logic [31:0]           r;
    logic                  e;

    always #2 CLK = ~CLK;

    ptis_top uut (
        .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .XFER_VALID(XFER_VALID), .XFER_READY(XFER_READY),
        .XFER_PORT(XFER_PORT), .XFER_ERROR(XFER_ERROR),
        .XFER_SIZE_MISMATCH(XFER_SIZE_MISMATCH), .XFER_COMMIT(XFER_COMMIT),
        .COMMIT_PORT(COMMIT_PORT),
        .DATA_TRANSFER_INTERRUPT_LINE(DATA_TRANSFER_INTERRUPT_LINE),
        .COMPARE_START(COMPARE_START), .COMPARE_PORT(COMPARE_PORT), .IRQ(IRQ)
    );

    // --------------------------------------------------------
    // Reporting
    // --------------------------------------------------------
    task final_report;
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task timeout_hit(input string what);
        bad_count++;
        $display("[FAIL] %0t no answer on %s", $time, what);
        final_report();
    endtask

    // --------------------------------------------------------
    // APB master, answer taken at the rising edge
    // --------------------------------------------------------
    task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            if (n > 20) timeout_hit("apb");
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
    endtask

    function automatic logic [5:0] sv(input logic k, input logic s, input logic n,
                                      input logic [2:0] sel);
        return 6'(ptis_setup_t'{k, s, n, sel});
    endfunction

    task cfg(input logic [3:0] p, input logic [5:0] s);
        wr(ADDR_PORT_INDEX, 32'(p));
        wr(ADDR_PORT_SETUP, 32'(s));
    endtask

    // --------------------------------------------------------
    // Transfer judge request and outcome watch
    // --------------------------------------------------------
    task xfer(input logic [3:0] p, input logic er, input logic mm,
              input logic [6:0] x_line, input int x_com, input int x_cmp);
        int n;
        int nc;
        int np;
        int ncm;
        int tc;
        int tl;
        logic [6:0] acc;
        @(posedge CLK);
        XFER_VALID         <= 1'b1;
        XFER_PORT          <= p;
        XFER_ERROR         <= er;
        XFER_SIZE_MISMATCH <= mm;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            if (n > 20) timeout_hit("xfer");
        end while (XFER_READY !== 1'b1);
        XFER_VALID <= 1'b0;
        acc = 7'h00;
        nc = 0;
        np = 0;
        ncm = 0;
        tc = 0;
        tl = 0;
        for (int i = 1; i <= 8; i++) begin
            @(negedge CLK);
            if (XFER_COMMIT === 1'b1) begin
                nc++;
                tc = i;
                chk(32'(COMMIT_PORT), 32'(p), "commit port");
            end
            if (DATA_TRANSFER_INTERRUPT_LINE !== 7'h00) begin
                np++;
                tl = i;
            end
            acc = acc | DATA_TRANSFER_INTERRUPT_LINE;
            if (COMPARE_START === 1'b1) begin
                ncm++;
                chk(32'(COMPARE_PORT), 32'(p), "compare port");
            end
        end
        chk(32'(acc), 32'(x_line), "line");
        chk(32'(np), (x_line != 7'h00) ? 32'h1 : 32'h0, "line pulses");
        chk(32'(nc), 32'(x_com), "commits");
        chk(32'(ncm), 32'(x_cmp), "compare starts");
        if (nc == 1 && np == 1) chk(32'(tl > tc), 32'h1, "commit before line");
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        rd_chk(ADDR_IRQ_STATUS, 32'h0, "status reset");
        rd_chk(ADDR_IRQ_MASK, 32'h0, "mask reset");
        rd_chk(ADDR_PORT_SETUP, 32'h0, "setup reset");
        chk(32'(IRQ), 32'h0, "irq reset");
        wr(ADDR_IRQ_MASK, 32'h7F);
        for (int s = 1; s <= 6; s++) begin
            cfg(4'h3, sv(1'b0, 1'b0, 1'b1, 3'(s)));
            rd_chk(ADDR_PORT_SETUP, 32'(sv(1'b0, 1'b0, 1'b1, 3'(s))), "setup back");
            xfer(4'h3, 1'b0, 1'b0, 7'(1 << (s - 1)), 1, 0);
            rd_chk(ADDR_IRQ_STATUS, 32'(1 << (s - 1)), "status set");
            chk(32'(IRQ), 32'h1, "irq up");
            wr(ADDR_IRQ_STATUS, 32'(1 << (s - 1)));
            rd_chk(ADDR_IRQ_STATUS, 32'h0, "status cleared");
            chk(32'(IRQ), 32'h0, "irq down");
        end
        cfg(4'h5, sv(1'b0, 1'b0, 1'b1, SEL_NONE));
        xfer(4'h5, 1'b0, 1'b0, 7'h00, 1, 0);
        cfg(4'h5, sv(1'b0, 1'b0, 1'b1, 3'h2));
        xfer(4'h5, 1'b1, 1'b0, 7'h00, 0, 0);
        cfg(4'h5, sv(1'b1, 1'b0, 1'b1, 3'h2));
        xfer(4'h5, 1'b1, 1'b0, 7'h02, 1, 0);
        xfer(4'h5, 1'b1, 1'b1, 7'h00, 0, 0);
        cfg(4'h6, sv(1'b0, 1'b1, 1'b0, 3'h4));
        xfer(4'h6, 1'b0, 1'b0, 7'h08, 1, 0);
        cfg(4'h6, sv(1'b1, 1'b1, 1'b1, 3'h4));
        xfer(4'h6, 1'b1, 1'b0, 7'h00, 0, 0);
        cfg(4'h7, sv(1'b0, 1'b0, 1'b1, SEL_SEVEN));
        xfer(4'h7, 1'b0, 1'b0, 7'h00, 1, 1);
        rd_chk(ADDR_COMPARE_CNT, 32'h1, "compare count");
        cfg(4'h7, sv(1'b0, 1'b1, 1'b1, SEL_SEVEN));
        xfer(4'h7, 1'b0, 1'b0, 7'h00, 1, 0);
        rd_chk(ADDR_IRQ_STATUS, 32'h0A, "status after mixed");
        wr(ADDR_IRQ_STATUS, 32'h7F);
        wr(ADDR_IRQ_MASK, 32'h01);
        cfg(4'h3, sv(1'b0, 1'b0, 1'b1, 3'h2));
        xfer(4'h3, 1'b0, 1'b0, 7'h02, 1, 0);
        chk(32'(IRQ), 32'h0, "irq masked");
        rd_chk(ADDR_IRQ_STATUS, 32'h02, "status masked");
        wr(ADDR_IRQ_MASK, 32'h02);
        @(negedge CLK);
        chk(32'(IRQ), 32'h1, "irq unmasked");
        wr(ADDR_IRQ_STATUS, 32'h02);
        @(negedge CLK);
        chk(32'(IRQ), 32'h0, "irq cleared");
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        apb(1'b1, 12'h014, 32'hFF, r, e);
        chk(32'(e), 32'h1, "unmapped write");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        timeout_hit("run");
    end
endmodule // ptis_top_test
